// [msu_pkg.sv]
package msu_pkg;
    // =====================================================================
    // Register map
    localparam logic [7:0] STATUS_ADDR      = 8'h6e;
    localparam logic [7:0] DONE_FLAGS_ADDR  = 8'h6f;
    localparam logic [7:0] DONE_FLAGS_RESET = 8'h00;
    // =====================================================================
    // Status field positions
    localparam int RATE_CTRL_BIT = 3;
    localparam int TXF_BIT       = 2;
    localparam int SCRATCH_BIT   = 1;
    localparam int NRDY_BIT      = 0;
    // =====================================================================
    // Done flag positions
    localparam int TEMP_DONE_BIT = 7;
    localparam int VCC_DONE_BIT  = 6;
    localparam int BIAS_DONE_BIT = 5;
    localparam int OPT_DONE_BIT  = 4;
    localparam int DONE_LSB      = 4;
    localparam int DONE_MSB      = 7;
    localparam int NUM_TX        = 2;
    // =====================================================================
    // Synchronised pin positions
    localparam int RATE_PIN      = 0;
    localparam int FAULT_ONE_PIN = 1;
    localparam int FAULT_TWO_PIN = 2;
    localparam int SUPPLY_PIN    = 3;
    localparam int NUM_PINS      = 4;
endpackage

// [msu_regs.sv]
module msu_regs (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Register access from the serial slave; i_view selects transmitter
    input  wire logic       i_view,
    input  wire logic [7:0] i_addr,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    output logic      [7:0] o_rd_data,
    // Pins
    input  wire logic       i_rate_select_input,
    input  wire logic       i_tx_fault_pin_one,
    input  wire logic       i_tx_fault_pin_two,
    input  wire logic       i_supply_ok,
    output logic            o_rate_select_output,
    // Conversion completions, one-cycle pulses per view
    input  wire logic [1:0] i_temp_done,
    input  wire logic [1:0] i_vcc_done,
    input  wire logic [1:0] i_bias_done,
    input  wire logic [1:0] i_opt_done
);
    // =====================================================================
    // Pin synchronisers, three stages; change taken when stages 2 and 3 agree.
    logic [msu_pkg::NUM_PINS-1:0] sync1_q, sync2_q, sync3_q, pin_q;
    logic [msu_pkg::NUM_PINS-1:0] sync1_d, pin_d;
    always_comb begin
        sync1_d = {i_supply_ok, i_tx_fault_pin_two, i_tx_fault_pin_one, i_rate_select_input};
        pin_d   = pin_q;
        for (int k = 0; k < msu_pkg::NUM_PINS; k++) begin
            if (sync2_q[k] == sync3_q[k]) begin
                pin_d[k] = sync3_q[k];
            end
        end
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pin_q   <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q   <= pin_d;
        end
    end
    // =====================================================================
    // Register state. The rate-select control is shared by both views.
    logic       rate_ctrl_q, rate_ctrl_d;
    logic [1:0] scratch_q, scratch_d;
    logic [3:0] done_q [msu_pkg::NUM_TX];
    logic [3:0] done_d [msu_pkg::NUM_TX];
    logic       wr_status, wr_done;
    assign wr_status = i_wr_en && (i_addr == msu_pkg::STATUS_ADDR);
    assign wr_done   = i_wr_en && (i_addr == msu_pkg::DONE_FLAGS_ADDR);

    always_comb begin
        rate_ctrl_d = rate_ctrl_q;
        scratch_d   = scratch_q;
        if (wr_status) begin
            rate_ctrl_d       = i_wr_data[msu_pkg::RATE_CTRL_BIT];
            scratch_d[i_view] = i_wr_data[msu_pkg::SCRATCH_BIT];
        end
    end

    // Hardware set wins over a host clear in the same cycle, so no event is lost.
    for (genvar v = 0; v < msu_pkg::NUM_TX; v++) begin : g_view
        logic [3:0] set_v;
        assign set_v = {i_temp_done[v], i_vcc_done[v], i_bias_done[v], i_opt_done[v]};
        always_comb begin
            done_d[v] = done_q[v];
            if (wr_done && (i_view == v[0])) begin
                done_d[v] = done_q[v] & i_wr_data[msu_pkg::DONE_MSB:msu_pkg::DONE_LSB];
            end
            done_d[v] = done_d[v] | set_v;
        end
        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                done_q[v] <= msu_pkg::DONE_FLAGS_RESET[7:msu_pkg::DONE_LSB];
            end else begin
                done_q[v] <= done_d[v];
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rate_ctrl_q <= 1'b0;
            scratch_q   <= 2'b00;
        end else begin
            rate_ctrl_q <= rate_ctrl_d;
            scratch_q   <= scratch_d;
        end
    end
    // =====================================================================
    // Outputs.
    logic       rate_out_q, rate_out_d;
    logic [7:0] rd_q, rd_d;
    always_comb begin
        rd_d = 8'h00;
        unique case (i_addr)
            msu_pkg::STATUS_ADDR: begin
                rd_d[msu_pkg::RATE_CTRL_BIT] = rate_ctrl_q;
                rd_d[msu_pkg::TXF_BIT]       = i_view ? pin_q[msu_pkg::FAULT_TWO_PIN]
                                                      : pin_q[msu_pkg::FAULT_ONE_PIN];
                rd_d[msu_pkg::SCRATCH_BIT]   = scratch_q[i_view];
                rd_d[msu_pkg::NRDY_BIT]      = ~pin_q[msu_pkg::SUPPLY_PIN];
            end
            msu_pkg::DONE_FLAGS_ADDR: begin
                rd_d = {done_q[i_view], 4'h0};
            end
            default: rd_d = 8'h00;
        endcase
    end

    // The output is the filtered pin ORed with the rate-select control, so a glitch lasting one sample on the input never reaches it.
    always_comb begin
        rate_out_d = pin_q[msu_pkg::RATE_PIN] | rate_ctrl_q;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_q       <= 8'h00;
            rate_out_q <= 1'b0;
        end else begin
            rd_q       <= rd_d;
            rate_out_q <= rate_out_d;
        end
    end
    assign o_rd_data            = rd_q;
    assign o_rate_select_output = rate_out_q;
    // =====================================================================
    // Checks.
    // Each check looks one cycle ahead, because both outputs are registered.

    // Rate select.
    rate_force_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        rate_ctrl_q |=> o_rate_select_output)
        else $error("rate select not forced");
    rate_or_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        1'b1 |=> (o_rate_select_output == ($past(pin_q[0]) | $past(rate_ctrl_q))))
        else $error("rate select output wrong");
    ctrl_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        wr_status |=> (rate_ctrl_q == $past(i_wr_data[msu_pkg::RATE_CTRL_BIT])))
        else $error("rate select control write lost");

    // Status and unmapped read back.
    fault_two_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr == msu_pkg::STATUS_ADDR && i_view)
        |=> (o_rd_data[msu_pkg::TXF_BIT] == $past(pin_q[msu_pkg::FAULT_TWO_PIN])))
        else $error("second fault mirror wrong");
    scratch_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr == msu_pkg::STATUS_ADDR && i_view)
        |=> (o_rd_data[msu_pkg::SCRATCH_BIT] == $past(scratch_q[1])))
        else $error("scratch read wrong");
    status_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr == msu_pkg::STATUS_ADDR) |=> (o_rd_data[7:4] == 4'h0))
        else $error("status upper bits not zero");
    other_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr != msu_pkg::STATUS_ADDR && i_addr != msu_pkg::DONE_FLAGS_ADDR)
        |=> (o_rd_data == 8'h00))
        else $error("unmapped read not zero");

    // Scratch copies.
    scratch_wr0_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_status && !i_view) |=> (scratch_q[0] == $past(i_wr_data[msu_pkg::SCRATCH_BIT])))
        else $error("first scratch write lost");
    scratch_sep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_status && i_view) |=> (scratch_q[0] == $past(scratch_q[0])))
        else $error("scratch copies not separate");

    // Done flags, then status and scratch.
    temp_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_temp_done[0] |=> done_q[0][msu_pkg::TEMP_DONE_BIT - msu_pkg::DONE_LSB])
        else $error("temperature flag not set");
    vcc_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_vcc_done[0] |=> done_q[0][msu_pkg::VCC_DONE_BIT - msu_pkg::DONE_LSB])
        else $error("supply flag not set");
    bias_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_bias_done[1] |=> done_q[1][msu_pkg::BIAS_DONE_BIT - msu_pkg::DONE_LSB])
        else $error("bias flag not set");
    opt_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_opt_done[1] |=> done_q[1][msu_pkg::OPT_DONE_BIT - msu_pkg::DONE_LSB])
        else $error("power flag not set");
    done_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_done && !i_view && !i_wr_data[msu_pkg::TEMP_DONE_BIT] && !i_temp_done[0])
        |=> !done_q[0][msu_pkg::TEMP_DONE_BIT - msu_pkg::DONE_LSB])
        else $error("done flag not cleared");
    done_sep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_done && i_view && !i_temp_done[0] && !i_vcc_done[0] && !i_bias_done[0]
            && !i_opt_done[0]) |=> (done_q[0] == $past(done_q[0])))
        else $error("done flag copies not separate");
    done_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr == msu_pkg::DONE_FLAGS_ADDR && !i_view)
        |=> (o_rd_data[msu_pkg::DONE_MSB:msu_pkg::DONE_LSB] == $past(done_q[0])))
        else $error("done flag read wrong");
    done_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!done_q[0][3] && !i_temp_done[0]) |=> !done_q[0][3])
        else $error("cleared flag set without conversion");
    done_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_vcc_done[1] |=> done_q[1][2])
        else $error("done flag not set");
    resv_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr == msu_pkg::DONE_FLAGS_ADDR) |=> (o_rd_data[3:0] == 4'h0))
        else $error("reserved bits not zero");
    nrdy_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr == msu_pkg::STATUS_ADDR) |=> (o_rd_data[0] == !$past(pin_q[3])))
        else $error("not ready flag wrong");
    fault_mirror_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_addr == msu_pkg::STATUS_ADDR && !i_view) |=> (o_rd_data[2] == $past(pin_q[1])))
        else $error("fault mirror wrong");
    scratch_wr_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_status && i_view) |=> (scratch_q[1] == $past(i_wr_data[1])))
        else $error("scratch write lost");
endmodule

// [msu_host_model.sv]
// =====================================================================
// Host side of the register port; data is scrambled once released.
module msu_host_model (
    // Clock and read data
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rd_data,
    // Register access
    output logic            o_view,
    output logic      [7:0] o_addr,
    output logic            o_wr_en,
    output logic      [7:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_view = 1'b0;
        o_addr = 8'h00;
        o_wr_en = 1'b0;
        o_wr_data = 8'h00;
    end
    // A zero written to a done flag re-arms it for the next conversion.
    task automatic wr(input logic v, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        {o_view, o_addr, o_wr_data, o_wr_en} = {v, a, d, 1'b1};
        @(negedge i_core_clk);
        o_wr_en = 1'b0;
        o_wr_data = ~d;
    endtask
    task automatic rd(input logic v, input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        {o_view, o_addr} = {v, a};
        @(negedge i_core_clk);
        d = i_rd_data;
    endtask
endmodule

// [msu_regs_tb_top.sv]
// =====================================================================
// Sequence of host accesses with expected values.
module msu_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       rate_in = 1'b0;
    logic       f1 = 1'b0;
    logic       f2 = 1'b0;
    logic       sok = 1'b1;
    logic [7:0] pl = 8'h00;
    logic       view, wr_en, rate_out;
    logic [7:0] addr, wdata, rdata, got;
    int         failures = 0;
    int         total_checks = 0;
    localparam logic [7:0] ST = msu_pkg::STATUS_ADDR;
    localparam logic [7:0] DN = msu_pkg::DONE_FLAGS_ADDR;
    always #12.5 clk = ~clk;
    msu_regs msu_regs_inst (.i_core_clk(clk), .i_rst(rst), .i_view(view), .i_addr(addr),
        .i_wr_en(wr_en), .i_wr_data(wdata), .o_rd_data(rdata), .i_rate_select_input(rate_in),
        .i_tx_fault_pin_one(f1), .i_tx_fault_pin_two(f2), .i_supply_ok(sok),
        .o_rate_select_output(rate_out), .i_temp_done(pl[7:6]), .i_vcc_done(pl[5:4]),
        .i_bias_done(pl[3:2]), .i_opt_done(pl[1:0]));
    msu_host_model msu_host_model_inst (.i_core_clk(clk), .i_rd_data(rdata), .o_view(view),
        .o_addr(addr), .o_wr_en(wr_en), .o_wr_data(wdata));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic v, input logic [7:0] a, m, e);
        msu_host_model_inst.rd(v, a, got);
        chk(n, e, got & m);
    endtask
    task automatic pulse(input logic [7:0] m);
        @(negedge clk);
        pl = m;
        @(negedge clk);
        pl = 8'h00;
    endtask
    // Pins pass a synchroniser and filter, so allow them time to land.
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        settle();
        rdchk("status0", 1'b0, ST, 8'h0d, 8'h00);
        rdchk("done0", 1'b0, DN, 8'hff, 8'h00);
        rdchk("done1", 1'b1, DN, 8'hff, 8'h00);
        rate_in = 1'b1;
        settle();
        chk("rate_pin", 8'h01, {7'h00, rate_out});
        rate_in = 1'b0;
        msu_host_model_inst.wr(1'b0, ST, 8'h08);
        settle();
        chk("rate_ctrl", 8'h01, {7'h00, rate_out});
        f1 = 1'b1;
        msu_host_model_inst.wr(1'b0, ST, 8'h0a);
        msu_host_model_inst.wr(1'b1, ST, 8'h08);
        settle();
        rdchk("status0b", 1'b0, ST, 8'h0f, 8'h0e);
        rdchk("status1b", 1'b1, ST, 8'h0f, 8'h08);
        pulse(8'h48);
        rdchk("done0b", 1'b0, DN, 8'hff, 8'h80);
        rdchk("done1b", 1'b1, DN, 8'hff, 8'h20);
        msu_host_model_inst.wr(1'b0, DN, 8'h0f);
        rdchk("done0c", 1'b0, DN, 8'hff, 8'h00);
        rdchk("done1c", 1'b1, DN, 8'hff, 8'h20);
        pulse(8'haa);
        msu_host_model_inst.wr(1'b1, DN, 8'hff);
        rdchk("done1d", 1'b1, DN, 8'hff, 8'hf0);
        msu_host_model_inst.wr(1'b1, ST, 8'h00);
        settle();
        chk("rate_off", 8'h00, {7'h00, rate_out});
        rdchk("status0d", 1'b0, ST, 8'h0a, 8'h02);
        sok = 1'b0;
        settle();
        rdchk("status0c", 1'b0, ST, 8'h01, 8'h01);
        final_report();
    end
endmodule
